// ### verilog/scan_output_defs.svh
// constant definitions for the scan output sequencer
`ifndef SCAN_OUTPUT_DEFS_SVH
`define SCAN_OUTPUT_DEFS_SVH

`define SOS_ADDR_W 5
`define SOS_WORD_W 10
`define SOS_ZERO_ADDR 5'h00
`define SOS_ZERO_WORD 10'h000
`define SOS_EVEN_MASK 5'h1e

`endif

// ### verilog/scan_output_pkg.sv
// types shared by the scan output sequencer
package scan_output_pkg;

    // sequencer states, one-hot, each tagged with the counter value it stands for
    typedef enum logic [9:0] {
        ST_IDLE   = 10'h001, // state 0
        ST_ARM    = 10'h002, // state 1
        ST_AREA   = 10'h004, // state 4
        ST_XPRES  = 10'h008, // state 5
        ST_XWAIT  = 10'h010, // state 5 waiting for acceptance
        ST_CHECK  = 10'h020, // state 6
        ST_REL    = 10'h040, // state 7
        ST_YPRES  = 10'h080, // state 8
        ST_YSTEP  = 10'h100, // state 9
        ST_YWAIT  = 10'h200  // states 10 and 12
    } seq_state_t;

    // word presented to data memory
    typedef struct packed {
        logic vertical_select;
        logic [9:0] value;
    } out_word_t;

    // per-half cache addressing status
    typedef struct packed {
        logic [4:0] addr;
        logic [4:0] latched;
    } cache_addr_t;

endpackage

// ### verilog/scan_output_sequencer.sv
// output sequencer that unloads one horizontal and its vertical words
// What this block does
// RL1: held in state 0 while digitize is inactive
// RL2: state 0 reloads until reset vertical counter request, then goes to 1
// RL3: state 1 jumps unconditionally to state 4
// RL4: state 4 returns to 0 unless data came from digital area
// RL5: state 5 raises registered word ready forming horizontal word ready
// RL6: horizontal phase drives vertical select low, routing horizontal count
// RL7: after presenting, wait for accepted; processor asserts then releases it
// RL8: state 6 checks cache empty; if empty wait release then state 0
// RL9: count latched and address counters cleared before vertical readout
// RL10: address below latch low at once if none stored, else until equal
// RL11: read pulse increments output half address, equality drops the flag
// RL12: cache empty uses the output half flag chosen by input select
// RL13: comparator ignores count lsb, so only even counts are read
// RL14: state 7 confirms release; state 8 raises ready and load word
// RL15: load word captures the output half word onto the output path
// RL16: state 9 produces read pulse advancing output half address
// RL17: state 10 waits accept; last word returns to 0, else 12 repeats
// RL18: processor counts horizontal words and ends digitize after wrap
// RL19: input select high makes half one input and half two output
// RL20: all outputs registered, transitions only on the sequencer clock
`timescale 1ns/1ps
`default_nettype none
`include "scan_output_defs.svh"

module scan_output_sequencer #(
    parameter int ADDR_W = `SOS_ADDR_W,
    parameter int WORD_W = `SOS_WORD_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic digitize_active,
    input wire logic reset_vertical_counter_req,
    input wire logic from_digital_area,
    input wire logic word_accepted,
    input wire logic half_one_input_select,
    input wire logic latch_cache_count,
    input wire logic clear_cache_counters,
    input wire logic [WORD_W-1:0] horizontal_count,
    input wire logic [WORD_W-1:0] half_one_word,
    input wire logic [WORD_W-1:0] half_two_word,
    input wire logic [ADDR_W-1:0] half_one_fill,
    input wire logic [ADDR_W-1:0] half_two_fill,
    output logic word_ready,
    output logic horizontal_word_ready,
    output logic vertical_word_ready,
    output logic vertical_select,
    output logic load_cache_word,
    output logic read_out_cache,
    output logic out_cache_empty,
    output logic [ADDR_W-1:0] half_one_addr,
    output logic [ADDR_W-1:0] half_two_addr,
    output logic [WORD_W-1:0] out_word
);

    // comparator ignoring the lsb of the latched count
    function automatic logic addr_below(input logic [ADDR_W-1:0] a,
                                        input logic [ADDR_W-1:0] l);
        logic [ADDR_W-1:0] m;
        m = l & ADDR_W'(`SOS_EVEN_MASK);
        addr_below = (a < m); // [RL10] [RL13]
    endfunction

    scan_output_pkg::seq_state_t state_r;
    logic [ADDR_W-1:0] latch_one_r;
    logic [ADDR_W-1:0] latch_two_r;
    logic [ADDR_W-1:0] addr_one_r;
    logic [ADDR_W-1:0] addr_two_r;
    logic horiz_phase_r;
    logic load_r;
    logic below_one;
    logic below_two;
    logic empty_now;

    // half two is output while select high, half one while low
    assign below_one = addr_below(addr_one_r, latch_one_r);
    assign below_two = addr_below(addr_two_r, latch_two_r);
    assign empty_now = half_one_input_select ? !below_two
                                             : !below_one; // [RL12] [RL19]

    // count latch and address counters, managed by the cache machines
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            latch_one_r <= `SOS_ZERO_ADDR;
            latch_two_r <= `SOS_ZERO_ADDR;
            addr_one_r <= `SOS_ZERO_ADDR;
            addr_two_r <= `SOS_ZERO_ADDR;
        end else begin
            if (latch_cache_count) begin
                latch_one_r <= half_one_fill; // [RL9]
                latch_two_r <= half_two_fill;
            end
            if (clear_cache_counters) begin
                addr_one_r <= `SOS_ZERO_ADDR; // [RL9]
                addr_two_r <= `SOS_ZERO_ADDR;
            end else if (state_r == scan_output_pkg::ST_YSTEP) begin
                // only the half in output mode steps; saturates at the top
                if (half_one_input_select) begin
                    if (addr_two_r != '1)
                        addr_two_r <= addr_two_r + 1'b1; // [RL11] [RL16]
                end else if (addr_one_r != '1) begin
                    addr_one_r <= addr_one_r + 1'b1; // [RL11] [RL16]
                end
            end
        end
    end

    // sequencer state walk
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !digitize_active) begin
            state_r <= scan_output_pkg::ST_IDLE; // [RL1]
        end else begin
            case (state_r)
                scan_output_pkg::ST_IDLE: begin
                    if (reset_vertical_counter_req)
                        state_r <= scan_output_pkg::ST_ARM; // [RL2]
                end
                scan_output_pkg::ST_ARM: begin
                    state_r <= scan_output_pkg::ST_AREA; // [RL3]
                end
                scan_output_pkg::ST_AREA: begin
                    if (from_digital_area)
                        state_r <= scan_output_pkg::ST_XPRES;
                    else
                        state_r <= scan_output_pkg::ST_IDLE; // [RL4]
                end
                scan_output_pkg::ST_XPRES: begin
                    state_r <= scan_output_pkg::ST_XWAIT;
                end
                scan_output_pkg::ST_XWAIT: begin
                    if (word_accepted)
                        state_r <= scan_output_pkg::ST_CHECK; // [RL7]
                end
                scan_output_pkg::ST_CHECK: begin
                    // empty: wait for release, then back to idle
                    if (empty_now) begin
                        if (!word_accepted)
                            state_r <= scan_output_pkg::ST_IDLE; // [RL8]
                    end else begin
                        state_r <= scan_output_pkg::ST_REL; // [RL8]
                    end
                end
                scan_output_pkg::ST_REL: begin
                    if (!word_accepted)
                        state_r <= scan_output_pkg::ST_YPRES; // [RL14]
                end
                scan_output_pkg::ST_YPRES: begin
                    state_r <= scan_output_pkg::ST_YSTEP; // [RL14]
                end
                scan_output_pkg::ST_YSTEP: begin
                    state_r <= scan_output_pkg::ST_YWAIT; // [RL16]
                end
                scan_output_pkg::ST_YWAIT: begin
                    // accepted: back to the empty check, which ends the scan after the last word
                    if (word_accepted)
                        state_r <= scan_output_pkg::ST_CHECK; // [RL17]
                end
                default: state_r <= scan_output_pkg::ST_IDLE;
            endcase
        end
    end

    // horizontal phase and load strobe, registered
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !digitize_active) begin
            horiz_phase_r <= 1'b0;
            load_r <= 1'b0;
        end else begin
            if (state_r == scan_output_pkg::ST_AREA)
                horiz_phase_r <= 1'b1; // [RL6]
            else if (state_r == scan_output_pkg::ST_REL)
                horiz_phase_r <= 1'b0;
            load_r <= (state_r == scan_output_pkg::ST_REL) &&
                      !word_accepted; // [RL14]
        end
    end

    // handshake outputs; ready holds until the processor accepts or digitize drops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            word_ready <= 1'b0;
            horizontal_word_ready <= 1'b0;
            vertical_word_ready <= 1'b0;
            vertical_select <= 1'b1;
            load_cache_word <= 1'b0;
            read_out_cache <= 1'b0;
            out_cache_empty <= 1'b1;
            out_word <= `SOS_ZERO_WORD;
        end else begin
            if (state_r == scan_output_pkg::ST_XPRES) begin
                word_ready <= 1'b1; // [RL5]
                horizontal_word_ready <= 1'b1; // [RL5]
            end else if (state_r == scan_output_pkg::ST_YPRES) begin
                word_ready <= 1'b1; // [RL14]
                vertical_word_ready <= 1'b1; // [RL14]
            end else if (word_accepted || !digitize_active) begin
                word_ready <= 1'b0; // [RL7]
                horizontal_word_ready <= 1'b0;
                vertical_word_ready <= 1'b0;
            end
            vertical_select <= !horiz_phase_r; // [RL6]
            load_cache_word <= load_r; // [RL20]
            read_out_cache <= (state_r == scan_output_pkg::ST_YSTEP); // [RL16]
            out_cache_empty <= empty_now; // [RL12]
            // horizontal count while in horizontal phase, else cache word on the load strobe
            if (horiz_phase_r)
                out_word <= horizontal_count; // [RL6]
            else if (load_r)
                out_word <= half_one_input_select ? half_two_word
                                                  : half_one_word; // [RL15]
        end
    end

    assign half_one_addr = addr_one_r;
    assign half_two_addr = addr_two_r;

    // assertions
    idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !digitize_active |=> state_r == scan_output_pkg::ST_IDLE) // [RL1]
        else $error("sequencer left idle without digitize");
    arm_jump_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_ARM && digitize_active
        |=> state_r == scan_output_pkg::ST_AREA) // [RL3]
        else $error("state 1 did not jump to state 4");
    area_back_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_AREA && !from_digital_area
        |=> state_r == scan_output_pkg::ST_IDLE) // [RL4]
        else $error("non digital area did not return to idle");
    x_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_XPRES && digitize_active
        |=> horizontal_word_ready && word_ready) // [RL5]
        else $error("horizontal ready not raised");
    x_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        horizontal_word_ready |-> !vertical_select) // [RL6]
        else $error("vertical select high during horizontal word");
    idle_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_IDLE && !reset_vertical_counter_req
        |=> state_r == scan_output_pkg::ST_IDLE) // [RL2]
        else $error("idle advanced without request");
    y_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_YPRES && digitize_active
        |=> vertical_word_ready && load_cache_word) // [RL14]
        else $error("vertical ready or load missing");
    read_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        read_out_cache |=> !read_out_cache) // [RL16]
        else $error("read pulse longer than one cycle");

    // horizontal word handshake

    // presenting lasts exactly one state before the wait
    x_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_XPRES && digitize_active
        |=> state_r == scan_output_pkg::ST_XWAIT) // [RL5]
        else $error("horizontal present did not move to wait");

    // no progress until the processor has stored the word
    x_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_XWAIT && !word_accepted &&
        digitize_active |=> state_r == scan_output_pkg::ST_XWAIT) // [RL7]
        else $error("horizontal wait left without acceptance");

    // ready must not drop before acceptance, or a word is lost
    ready_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        word_ready && !word_accepted && digitize_active
        |=> word_ready) // [RL7]
        else $error("word ready dropped before acceptance");

    // empty decision after each word

    // empty cache ends the scan once acceptance is released
    check_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_CHECK && empty_now &&
        !word_accepted && digitize_active
        |=> state_r == scan_output_pkg::ST_IDLE) // [RL8]
        else $error("empty cache did not end the scan");

    // words left in the cache start vertical readout
    check_go_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_CHECK && !empty_now &&
        digitize_active |=> state_r == scan_output_pkg::ST_REL) // [RL8]
        else $error("cache with words did not start readout");

    // a held acceptance keeps the next word back
    rel_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_REL && word_accepted &&
        digitize_active |=> state_r == scan_output_pkg::ST_REL) // [RL14]
        else $error("next word presented before release");

    // no stored pair means empty at once, odd last value ignored
    none_stored_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !half_one_input_select &&
        (latch_one_r & ADDR_W'(`SOS_EVEN_MASK)) == `SOS_ZERO_ADDR
        |-> empty_now) // [RL10] [RL13]
        else $error("empty not reported with nothing stored");

    // vertical words

    // vertical word goes out with the select high
    y_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        vertical_word_ready |-> vertical_select) // [RL6]
        else $error("vertical select low during vertical word");

    // load strobe is a single cycle
    load_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        load_cache_word |=> !load_cache_word) // [RL14]
        else $error("load strobe longer than one cycle");

    // registered load strobe leads to the read pulse
    load_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_YSTEP
        |-> load_cache_word ##1 read_out_cache) // [RL16]
        else $error("read pulse did not follow load strobe");

    // acceptance of a vertical word leads back to the empty check
    y_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_YWAIT && word_accepted &&
        digitize_active |=> state_r == scan_output_pkg::ST_CHECK) // [RL17]
        else $error("vertical acceptance did not reach check");

    // cache addressing

    // half two steps while it is the output half
    step_two_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_YSTEP && half_one_input_select &&
        !clear_cache_counters && addr_two_r != '1
        |=> addr_two_r == ADDR_W'($past(addr_two_r) + 1'b1)) // [RL11]
        else $error("half two address did not step");

    // half one steps while it is the output half
    step_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == scan_output_pkg::ST_YSTEP && !half_one_input_select &&
        !clear_cache_counters && addr_one_r != '1
        |=> addr_one_r == ADDR_W'($past(addr_one_r) + 1'b1)) // [RL19]
        else $error("half one address did not step");

    // clear brings both halves back to address zero
    clear_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clear_cache_counters |=> addr_one_r == `SOS_ZERO_ADDR &&
        addr_two_r == `SOS_ZERO_ADDR) // [RL9]
        else $error("address counters not cleared");

    // latch captures both halves' fill counts one cycle after latch_cache_count
    latch_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        latch_cache_count |=> latch_one_r == $past(half_one_fill) &&
        latch_two_r == $past(half_two_fill)) // [RL9]
        else $error("fill count not latched");

    // main scenarios
    cover_x: cover property (@(posedge ref_clk) horizontal_word_ready);
    cover_y: cover property (@(posedge ref_clk) vertical_word_ready);
    cover_empty: cover property (@(posedge ref_clk)
        state_r == scan_output_pkg::ST_CHECK && empty_now);
    cover_outside: cover property (@(posedge ref_clk)
        state_r == scan_output_pkg::ST_AREA && !from_digital_area);
    cover_loop: cover property (@(posedge ref_clk)
        state_r == scan_output_pkg::ST_YWAIT && word_accepted);

endmodule
`default_nettype wire

// ### bench/word_sink_model.sv
// processor-side model that stores each presented word and accepts it on the same edge
`timescale 1ns/1ps
`default_nettype none
module word_sink_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic word_ready,
    input wire logic horizontal_word_ready,
    input wire logic vertical_select,
    input wire logic [9:0] out_word,
    input wire logic [3:0] stall,
    output logic word_accepted
);
    scan_output_pkg::out_word_t got [64];
    logic hx [64];
    logic [3:0] wait_r;
    int count;

    // store after a stall of at least three cycles, so a vertical word has
    // been loaded onto the output path before it is taken
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            word_accepted <= 1'b0;
            wait_r <= 4'h0;
            count <= 0;
        end else if (word_accepted) begin
            if (!word_ready) begin
                word_accepted <= 1'b0; // release once ready drops
            end
        end else if (word_ready) begin
            if (wait_r == stall) begin
                got[count] <= '{vertical_select, out_word};
                hx[count] <= horizontal_word_ready;
                count <= count + 1;
                word_accepted <= 1'b1; // accept on the same edge as storing
                wait_r <= 4'h0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/scan_output_sequencer_tb.sv
// self-checking testbench for the scan output sequencer
`timescale 1ns/1ps
`default_nettype none
module scan_output_sequencer_tb;
    logic ref_clk, rst_n, digitize_active, reset_vertical_counter_req;
    logic from_digital_area, word_accepted, half_one_input_select;
    logic latch_cache_count, clear_cache_counters;
    logic [9:0] horizontal_count, half_one_word, half_two_word, out_word;
    logic [4:0] half_one_fill, half_two_fill, half_one_addr, half_two_addr;
    logic word_ready, horizontal_word_ready, vertical_word_ready;
    logic vertical_select, load_cache_word, read_out_cache, out_cache_empty;
    logic [3:0] stall;
    logic [9:0] mem1 [32];
    logic [9:0] mem2 [32];
    int errors, checks;
    int loads, reads, ys;

    // count strobes and accepted vertical words as the processor sees them
    always @(posedge ref_clk) begin
        if (load_cache_word) loads++;
        if (read_out_cache) reads++;
        if (vertical_word_ready && word_accepted) ys++;
    end

    // cache halves modelled as arrays read at the block's own addresses
    assign half_one_word = mem1[half_one_addr];
    assign half_two_word = mem2[half_two_addr];

    scan_output_sequencer u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .digitize_active(digitize_active),
        .reset_vertical_counter_req(reset_vertical_counter_req),
        .from_digital_area(from_digital_area), .word_accepted(word_accepted),
        .half_one_input_select(half_one_input_select),
        .latch_cache_count(latch_cache_count),
        .clear_cache_counters(clear_cache_counters),
        .horizontal_count(horizontal_count), .half_one_word(half_one_word),
        .half_two_word(half_two_word), .half_one_fill(half_one_fill),
        .half_two_fill(half_two_fill), .word_ready(word_ready),
        .horizontal_word_ready(horizontal_word_ready),
        .vertical_word_ready(vertical_word_ready),
        .vertical_select(vertical_select), .load_cache_word(load_cache_word),
        .read_out_cache(read_out_cache), .out_cache_empty(out_cache_empty),
        .half_one_addr(half_one_addr), .half_two_addr(half_two_addr),
        .out_word(out_word));

    word_sink_model u_sink (.ref_clk(ref_clk), .rst_n(rst_n),
        .word_ready(word_ready), .horizontal_word_ready(horizontal_word_ready),
        .vertical_select(vertical_select), .out_word(out_word),
        .stall(stall), .word_accepted(word_accepted));

    task check(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task tally_and_finish;
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task step;
        @(posedge ref_clk);
        #1;
    endtask

    // one scan: latch the fill, request, collect words, compare
    task run_scan(input logic digitize_line, area, sel, input logic [4:0] fill,
                  input logic [3:0] st);
        int base, ny, n, lat, i, lb, rb, yb;
        logic [9:0] exp_w;
        base = u_sink.count;
        lb = loads;
        rb = reads;
        yb = ys;
        ny = (digitize_line && area) ? int'(fill & 5'h1e) : 0;
        n = (digitize_line && area) ? ny + 1 : 0;
        digitize_active = digitize_line; // digitize level for this scan; held low, state 0 refuses the request
        from_digital_area = area;
        half_one_input_select = sel;
        stall = st;
        half_one_fill = fill;
        half_two_fill = fill;
        horizontal_count = horizontal_count + 10'h011;
        latch_cache_count = 1'b1;
        clear_cache_counters = 1'b1;
        step;
        latch_cache_count = 1'b0;
        clear_cache_counters = 1'b0;
        reset_vertical_counter_req = 1'b1;
        step;
        reset_vertical_counter_req = 1'b0;
        lat = 1;
        while (!word_ready && lat < 12) begin
            step;
            lat++;
        end
        if (n > 0) check("ready latency", lat, 4);
        else check("ready refused", word_ready, 1'b0);
        for (i = 0; i < 600 && (u_sink.count != base + n || word_ready); i++)
            step;
        repeat (20) step;
        check("word count", u_sink.count - base, n);
        for (i = 0; i < n; i++) begin
            exp_w = (i == 0) ? horizontal_count :
                    (sel ? mem2[i - 1] : mem1[i - 1]);
            check("word", u_sink.got[base + i].value, exp_w);
            check("select", u_sink.got[base + i].vertical_select, i != 0);
            check("x ready", u_sink.hx[base + i], i == 0);
        end
        if (n > 0)
            check("out addr", sel ? half_two_addr : half_one_addr, ny);
        check("load count", loads - lb, ny);
        check("read count", reads - rb, ny);
        check("y ready count", ys - yb, ny);
        if (n > 0) check("cache empty", out_cache_empty, 1'b1);
    endtask

    task scan_refused_idle;
        run_scan(1'b0, 1'b1, 1'b1, 5'h06, 4'h3);
    endtask
    task scan_outside_area;
        run_scan(1'b1, 1'b0, 1'b1, 5'h06, 4'h3);
    endtask
    task scan_odd_half_two;
        run_scan(1'b1, 1'b1, 1'b1, 5'h05, 4'h3);
    endtask
    task scan_empty_cache;
        run_scan(1'b1, 1'b1, 1'b0, 5'h00, 4'h3);
    endtask
    task scan_full_half_one_slow;
        run_scan(1'b1, 1'b1, 1'b0, 5'h1f, 4'h8);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // watchdog well beyond the longest expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        tally_and_finish;
    end

    initial begin
        rst_n = 1'b0;
        {digitize_active, reset_vertical_counter_req, from_digital_area} = 3'h0;
        {half_one_input_select, latch_cache_count, clear_cache_counters} = 3'h0;
        horizontal_count = 10'h040;
        half_one_fill = 5'h00;
        half_two_fill = 5'h00;
        stall = 4'h3;
        errors = 0;
        checks = 0;
        loads = 0;
        reads = 0;
        ys = 0;
        for (int i = 0; i < 32; i++) begin
            mem1[i] = 10'h100 + 10'(i);
            mem2[i] = 10'h200 + 10'(i);
        end
        repeat (8) step;
        check("reset ready", word_ready, 1'b0);
        check("reset select", vertical_select, 1'b1);
        rst_n = 1'b1;
        scan_refused_idle;
        scan_outside_area;
        scan_odd_half_two;
        scan_odd_half_two;
        scan_empty_cache;
        scan_full_half_one_slow;
        tally_and_finish;
    end
endmodule
`default_nettype wire
